/* File: verilog/level_ctrl_pkg.sv */
// Summary of operation
// RULE1 - With the enable bit (bit 8 at 0x20) set, the block drives the gain.
// RULE2 - With the enable bit clear, the gain is the manual gain field as is.
// RULE3 - Rises wait a hold of 0, or 2 ms doubled per code up to 512 ms at 9.
// RULE4 - The target is -28.5 dBFS plus 1.5 dB per code, up to -6 dBFS.
// RULE5 - Normal step: 500 us up or 125 us down at code 0, doubled to code 10.
// RULE6 - Limiter step: 125 us up or 31 us down at code 0, doubled to code 10.
// RULE7 - One gain step is 0.75 dB, so eight steps make a 6 dB change.
// RULE8 - Software should keep zero-crossing update off while the loop runs.
// RULE9 - The automatic gain is clamped between the lower and upper limits.
// RULE10 - Above target the gain falls; below it past the hold it rises.
package level_ctrl_pkg;

    localparam logic [6:0] OFS_ENABLE_LIMITS = 7'h20;
    localparam logic [6:0] OFS_HOLD_TARGET   = 7'h21;
    localparam logic [6:0] OFS_MODE_RATES    = 7'h22;

    localparam logic [8:0] RST_ENABLE_LIMITS = 9'h038;
    localparam logic [8:0] RST_HOLD_TARGET   = 9'h00b;
    localparam logic [8:0] RST_MODE_RATES    = 9'h032;

    localparam int BIT_ENABLE      = 8;
    localparam int BIT_ZERO_CROSS  = 8;
    localparam int BIT_LIMITER     = 8;
    localparam int POS_UPPER_LIMIT = 3;
    localparam int POS_LOWER_LIMIT = 0;
    localparam int POS_HOLD        = 4;
    localparam int POS_TARGET      = 0;
    localparam int POS_RISE_RATE   = 4;
    localparam int POS_FALL_RATE   = 0;

    // Gain index in 0.75 dB steps, index 0 is -12 dB.
    localparam logic [5:0] LIMIT_STEPS     = 6'h08;
    localparam logic [5:0] UPPER_OFFSET    = 6'h07;
    localparam logic [3:0] RATE_CAP_CODE   = 4'ha;
    localparam logic [3:0] HOLD_CAP_CODE   = 4'h9;

    localparam int CLK_PERIOD_PS     = 4000;
    localparam int RISE_NORM_NS      = 500000;
    localparam int FALL_NORM_NS      = 125000;
    localparam int RISE_LIM_NS       = 125000;
    localparam int FALL_LIM_NS       = 31000;
    localparam int HOLD_BASE_NS      = 2000000;
    localparam int RISE_NORM_CYC = RISE_NORM_NS * 1000 / CLK_PERIOD_PS;
    localparam int FALL_NORM_CYC = FALL_NORM_NS * 1000 / CLK_PERIOD_PS;
    localparam int RISE_LIM_CYC  = RISE_LIM_NS * 1000 / CLK_PERIOD_PS;
    localparam int FALL_LIM_CYC  = FALL_LIM_NS * 1000 / CLK_PERIOD_PS;
    localparam int HOLD_BASE_CYC = HOLD_BASE_NS / CLK_PERIOD_PS * 1000;

    localparam int TIMER_W = 28;

    // Target thresholds on a 16-bit sample magnitude, full scale 32768.
    localparam logic [15:0] TARGET_TABLE [16] = '{
        16'h04cf, 16'h05b8, 16'h06cc, 16'h0814,
        16'h0999, 16'h0b68, 16'h0d8f, 16'h101d,
        16'h1327, 16'h16c3, 16'h1b0d, 16'h2027,
        16'h2636, 16'h2d6a, 16'h35fa, 16'h4027
    };

    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [8:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] magnitude;
    } level_s;

    typedef enum logic [1:0] {
        ST_MANUAL,
        ST_FALLING,
        ST_HOLDING,
        ST_RISING
    } ctl_state_e;

endpackage

/* File: verilog/step_timer.sv */
module step_timer (
    input  wire logic                             i_ref_clk,
    input  wire logic                             i_sys_rst,
    input  wire logic                             i_run,
    input  wire logic [level_ctrl_pkg::TIMER_W-1:0] i_period,
    output logic                                  o_expire
);
    typedef struct packed {
        logic [level_ctrl_pkg::TIMER_W-1:0] count;
        logic                               expire;
    } timer_s;

    timer_s state;
    timer_s next_state;

    always_comb begin
        next_state = state;
        next_state.expire = 1'b0;
        if (!i_run) begin
            next_state.count = '0;
        end else if (state.count + 1'b1 >= i_period) begin
            next_state.count = '0;
            next_state.expire = 1'b1;
        end else begin
            next_state.count = state.count + 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_expire = state.expire;
endmodule

/* File: verilog/automatic_level_control.sv */
module automatic_level_control #(
    parameter int RISE_NORM_CYC = level_ctrl_pkg::RISE_NORM_CYC,
    parameter int FALL_NORM_CYC = level_ctrl_pkg::FALL_NORM_CYC,
    parameter int RISE_LIM_CYC  = level_ctrl_pkg::RISE_LIM_CYC,
    parameter int FALL_LIM_CYC  = level_ctrl_pkg::FALL_LIM_CYC,
    parameter int HOLD_BASE_CYC = level_ctrl_pkg::HOLD_BASE_CYC
) (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_sys_rst,
    input  wire level_ctrl_pkg::reg_req_s i_reg_req,
    input  wire level_ctrl_pkg::level_s   i_level,
    input  wire logic [5:0]               i_manual_input_gain,
    output logic [8:0]                    o_reg_rdata,
    output logic [5:0]                    o_input_gain,
    output logic                          o_zero_cross_update,
    output logic                          o_level_above
);
    localparam int TW = level_ctrl_pkg::TIMER_W;

    typedef struct packed {
        logic [8:0]                 enable_limits;
        logic [8:0]                 hold_target;
        logic [8:0]                 mode_rates;
        logic [8:0]                 rdata;
        level_ctrl_pkg::ctl_state_e phase;
        logic [5:0]                 gain;
        logic                       above;
        logic [TW-1:0]              hold_count;
    } ctl_s;

    ctl_s state;
    ctl_s next_state;

    logic          enable;
    logic          limiter;
    logic [3:0]    hold_code;
    logic [3:0]    target_code;
    logic [3:0]    rise_code;
    logic [3:0]    fall_code;
    logic [5:0]    lower_gain;
    logic [5:0]    upper_gain;
    logic [TW-1:0] rise_period;
    logic [TW-1:0] fall_period;
    logic [TW-1:0] hold_period;
    logic [TW-1:0] step_period;
    logic          step_run;
    logic          step_due;

    always_comb begin
        enable      = state.enable_limits[level_ctrl_pkg::BIT_ENABLE];
        limiter     = state.mode_rates[level_ctrl_pkg::BIT_LIMITER];
        hold_code   = state.hold_target[level_ctrl_pkg::POS_HOLD +: 4];
        target_code = state.hold_target[level_ctrl_pkg::POS_TARGET +: 4];
        rise_code   = state.mode_rates[level_ctrl_pkg::POS_RISE_RATE +: 4];
        fall_code   = state.mode_rates[level_ctrl_pkg::POS_FALL_RATE +: 4];
        if (rise_code > level_ctrl_pkg::RATE_CAP_CODE) begin
            rise_code = level_ctrl_pkg::RATE_CAP_CODE; // RULE5
        end
        if (fall_code > level_ctrl_pkg::RATE_CAP_CODE) begin
            fall_code = level_ctrl_pkg::RATE_CAP_CODE; // RULE6
        end
        // Each period is the code-0 step time doubled once per code.
        if (limiter) begin
            rise_period = TW'(RISE_LIM_CYC) << rise_code; // RULE6
            fall_period = TW'(FALL_LIM_CYC) << fall_code; // RULE6
        end else begin
            rise_period = TW'(RISE_NORM_CYC) << rise_code; // RULE5
            fall_period = TW'(FALL_NORM_CYC) << fall_code; // RULE5
        end
        if (hold_code == 4'h0) begin
            hold_period = '0; // RULE3
        end else if (hold_code > level_ctrl_pkg::HOLD_CAP_CODE) begin
            hold_period = TW'(HOLD_BASE_CYC) << 8; // RULE3
        end else begin
            hold_period = TW'(HOLD_BASE_CYC) << (hold_code - 4'h1); // RULE3
        end
        lower_gain = level_ctrl_pkg::LIMIT_STEPS
                   * 6'(state.enable_limits[
                       level_ctrl_pkg::POS_LOWER_LIMIT +: 3]); // RULE9
        upper_gain = level_ctrl_pkg::LIMIT_STEPS
                   * 6'(state.enable_limits[
                       level_ctrl_pkg::POS_UPPER_LIMIT +: 3])
                   + level_ctrl_pkg::UPPER_OFFSET; // RULE9
        step_run    = (state.phase == level_ctrl_pkg::ST_FALLING)
                   || (state.phase == level_ctrl_pkg::ST_RISING);
        step_period = (state.phase == level_ctrl_pkg::ST_FALLING)
                   ? fall_period : rise_period;
    end

    step_timer u_step_timer (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_run     (step_run),
        .i_period  (step_period),
        .o_expire  (step_due)
    );

    always_comb begin
        next_state = state;

        if (i_reg_req.wr) begin
            unique case (i_reg_req.addr)
                level_ctrl_pkg::OFS_ENABLE_LIMITS:
                    next_state.enable_limits = i_reg_req.wdata & 9'h13f;
                level_ctrl_pkg::OFS_HOLD_TARGET:
                    next_state.hold_target = i_reg_req.wdata;
                level_ctrl_pkg::OFS_MODE_RATES:
                    next_state.mode_rates = i_reg_req.wdata;
                default: ;
            endcase
        end
        unique case (i_reg_req.addr)
            level_ctrl_pkg::OFS_ENABLE_LIMITS:
                next_state.rdata = state.enable_limits;
            level_ctrl_pkg::OFS_HOLD_TARGET:
                next_state.rdata = state.hold_target;
            level_ctrl_pkg::OFS_MODE_RATES:
                next_state.rdata = state.mode_rates;
            default:
                next_state.rdata = 9'h000;
        endcase

        if (i_level.valid) begin
            next_state.above = i_level.magnitude
                > level_ctrl_pkg::TARGET_TABLE[target_code]; // RULE4
        end

        if (!enable) begin
            next_state.phase      = level_ctrl_pkg::ST_MANUAL;
            next_state.gain       = i_manual_input_gain; // RULE2
            next_state.hold_count = '0;
        end else begin
            unique case (state.phase)
                level_ctrl_pkg::ST_MANUAL: begin
                    // Start from the manual gain so the handover is smooth.
                    next_state.phase = level_ctrl_pkg::ST_HOLDING; // RULE1
                end
                level_ctrl_pkg::ST_FALLING: begin
                    if (!state.above) begin
                        next_state.phase = level_ctrl_pkg::ST_HOLDING;
                    end else if (step_due && state.gain > lower_gain) begin
                        next_state.gain = state.gain - 6'h01; // RULE7
                    end
                end
                level_ctrl_pkg::ST_HOLDING: begin
                    if (state.above) begin
                        next_state.phase = level_ctrl_pkg::ST_FALLING; // RULE10
                        next_state.hold_count = '0;
                    end else if (state.hold_count >= hold_period) begin
                        next_state.phase = level_ctrl_pkg::ST_RISING; // RULE3
                        next_state.hold_count = '0;
                    end else begin
                        next_state.hold_count = state.hold_count + 1'b1;
                    end
                end
                level_ctrl_pkg::ST_RISING: begin
                    if (state.above) begin
                        next_state.phase = level_ctrl_pkg::ST_FALLING; // RULE10
                    end else if (step_due && state.gain < upper_gain) begin
                        next_state.gain = state.gain + 6'h01; // RULE7
                    end
                end
            endcase
            // Limits may move under a running loop, so clamp every cycle.
            if (next_state.gain > upper_gain) begin
                next_state.gain = upper_gain; // RULE9
            end else if (next_state.gain < lower_gain) begin
                next_state.gain = lower_gain; // RULE9
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state               <= '0;
            state.enable_limits <= level_ctrl_pkg::RST_ENABLE_LIMITS;
            state.hold_target   <= level_ctrl_pkg::RST_HOLD_TARGET;
            state.mode_rates    <= level_ctrl_pkg::RST_MODE_RATES;
            state.phase         <= level_ctrl_pkg::ST_MANUAL;
        end else begin
            state <= next_state;
        end
    end

    assign o_reg_rdata         = state.rdata;
    assign o_input_gain        = state.gain;
    assign o_level_above       = state.above;
    // The option is only passed on; keeping it off with the loop is software's job.
    assign o_zero_cross_update =
        state.hold_target[level_ctrl_pkg::BIT_ZERO_CROSS]; // RULE8
endmodule

/* File: dv/level_ctrl_asserts.sv */
module level_ctrl_asserts #(
    parameter int RISE_NORM_CYC = 8,
    parameter int FALL_NORM_CYC = 2,
    parameter int RISE_LIM_CYC  = 2,
    parameter int FALL_LIM_CYC  = 1,
    parameter int HOLD_BASE_CYC = 16
) (
    input wire logic                     i_ref_clk,
    input wire logic                     i_sys_rst,
    input wire level_ctrl_pkg::reg_req_s i_reg_req,
    input wire level_ctrl_pkg::level_s   i_level,
    input wire logic [5:0]               i_manual_input_gain,
    input wire logic [5:0]               o_input_gain,
    input wire logic                     o_level_above
);
    logic [8:0] r0, r1, r2;
    logic [5:0] gain_d;
    logic [1:0] wr_d, dir;
    logic       en_d, quiet, chg, up;
    logic [3:0] fc, rc, hc;
    int         cnt, fall_p, rise_p, hold_c;
    // Cycles since the level was last seen above target, to time the hold.
    int         qcnt;

    // Steps are only judged once the settings have been stable two cycles.
    always_comb begin
        fc = (r2[3:0] > 4'ha) ? 4'ha : r2[3:0];
        rc = (r2[7:4] > 4'ha) ? 4'ha : r2[7:4];
        hc = (r1[7:4] > 4'h9) ? 4'h9 : r1[7:4];
        fall_p = (r2[8] ? FALL_LIM_CYC : FALL_NORM_CYC) << fc;
        rise_p = (r2[8] ? RISE_LIM_CYC : RISE_NORM_CYC) << rc;
        hold_c = (hc == 4'h0) ? 0 : HOLD_BASE_CYC << (hc - 4'h1);
        quiet = r0[8] && en_d && (wr_d == 2'b00);
        chg = o_input_gain != gain_d;
        up = o_input_gain > gain_d;
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            r0 <= 9'h038;
            r1 <= 9'h00b;
            r2 <= 9'h032;
            gain_d <= 6'h00;
            wr_d <= 2'b00;
            dir <= 2'b00;
            en_d <= 1'b0;
            cnt <= 0;
            qcnt <= 0;
        end else begin
            if (i_reg_req.wr && i_reg_req.addr == 7'h20) r0 <= i_reg_req.wdata & 9'h13f;
            if (i_reg_req.wr && i_reg_req.addr == 7'h21) r1 <= i_reg_req.wdata;
            if (i_reg_req.wr && i_reg_req.addr == 7'h22) r2 <= i_reg_req.wdata;
            gain_d <= o_input_gain;
            wr_d <= {wr_d[0], i_reg_req.wr};
            en_d <= r0[8];
            cnt <= chg ? 1 : cnt + 1;
            qcnt <= o_level_above ? 0 : qcnt + 1;
            if (!quiet) dir <= 2'b00;
            else if (chg) dir <= up ? 2'b01 : 2'b10;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_step;
        quiet && chg;
    endsequence
    sequence s_above_run;
        o_level_above [*4];
    endsequence

    a_manual_gain:
        assert property (!r0[8] |=>
            o_input_gain == $past(i_manual_input_gain))
        else $error("Gain does not follow the manual field.");
    a_single_step:
        assert property (s_step |-> o_input_gain == gain_d + 6'h01
            || o_input_gain == gain_d - 6'h01)
        else $error("Automatic gain moved by more than one step.");
    a_gain_limits:
        assert property (quiet |-> o_input_gain >= {r0[2:0], 3'h0}
            && o_input_gain <= {r0[5:3], 3'h7})
        else $error("Automatic gain outside its limits.");
    a_level_compare:
        assert property (i_level.valid |=> o_level_above
            == ($past(i_level.magnitude)
            > level_ctrl_pkg::TARGET_TABLE[$past(r1[3:0])]))
        else $error("Level flag disagrees with the target.");
    a_fall_spacing:
        assert property (s_step and (!up && dir == 2'b10) |-> cnt >= fall_p)
        else $error("Gain fell faster than the fall rate.");
    a_rise_spacing:
        assert property (s_step and (up && dir == 2'b01) |-> cnt >= rise_p)
        else $error("Gain rose faster than the rise rate.");
    // The first rise after a fall must wait out the hold and a full step.
    a_hold_rise:
        assert property (s_step and (up && dir == 2'b10)
            |-> qcnt > hold_c + rise_p)
        else $error("Gain rose before the hold time ran out.");
    a_no_rise_above:
        assert property (s_above_run |=> !(quiet && chg && up))
        else $error("Gain rose while the level was above target.");
endmodule

bind automatic_level_control level_ctrl_asserts #(
    .RISE_NORM_CYC(RISE_NORM_CYC),
    .FALL_NORM_CYC(FALL_NORM_CYC),
    .RISE_LIM_CYC (RISE_LIM_CYC),
    .FALL_LIM_CYC (FALL_LIM_CYC),
    .HOLD_BASE_CYC(HOLD_BASE_CYC)
) u_chk (
    .i_ref_clk          (i_ref_clk),
    .i_sys_rst          (i_sys_rst),
    .i_reg_req          (i_reg_req),
    .i_level            (i_level),
    .i_manual_input_gain(i_manual_input_gain),
    .o_input_gain       (o_input_gain),
    .o_level_above      (o_level_above)
);

/* File: dv/automatic_level_control_test.sv */
module automatic_level_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int R_N = 8, F_N = 2, R_L = 2, F_L = 1, H_B = 16;
    logic                     i_ref_clk = 1'b0;
    logic                     i_sys_rst = 1'b1;
    level_ctrl_pkg::reg_req_s i_reg_req = '0;
    level_ctrl_pkg::level_s   i_level = '0;
    logic [5:0]               i_manual_input_gain = 6'h00;
    logic [8:0]               o_reg_rdata, d;
    logic [5:0]               o_input_gain;
    logic                     o_zero_cross_update, o_level_above;
    logic [15:0]              mag = 16'h0000;
    int                       failures = 0, checked = 0, cyc = 0;

    automatic_level_control #(.RISE_NORM_CYC(R_N), .FALL_NORM_CYC(F_N),
        .RISE_LIM_CYC(R_L), .FALL_LIM_CYC(F_L), .HOLD_BASE_CYC(H_B)) u_dut (
        .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_reg_req(i_reg_req),
        .i_level(i_level), .i_manual_input_gain(i_manual_input_gain),
        .o_reg_rdata(o_reg_rdata), .o_input_gain(o_input_gain),
        .o_zero_cross_update(o_zero_cross_update), .o_level_above(o_level_above));

    always #2 i_ref_clk = ~i_ref_clk;

    // A sample strobe every fourth cycle keeps the level measurement fed.
    always @(posedge i_ref_clk) begin
        #1;
        cyc++;
        i_level.valid = (cyc % 4 == 0);
        i_level.magnitude = mag;
        if (cyc > 100000) begin
            failures++;
            results();
        end
    end

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [8:0] v);
        i_reg_req = '{wr: 1'b1, addr: a, wdata: v};
        @(posedge i_ref_clk);
        #1 i_reg_req.wr = 1'b0;
        // One idle edge keeps the strobe from being lowered and raised in
        // the same time step when writes follow each other.
        @(posedge i_ref_clk);
        #1;
    endtask

    task automatic rd(input logic [6:0] a, input logic [8:0] e);
        i_reg_req.addr = a;
        @(posedge i_ref_clk);
        #1 chk("rdata", 16'(e), 16'(o_reg_rdata));
    endtask

    // Waits for the next gain change; dt is edges waited, dl the signed move.
    task automatic step(input int lim, output int dt, output int dl);
        logic [5:0] g;
        g = o_input_gain;
        dt = 0;
        while (o_input_gain === g && dt < lim) begin
            @(posedge i_ref_clk);
            #1 dt++;
        end
        dl = int'(o_input_gain) - int'(g);
    endtask

    task automatic run(input logic md, input int rc, input int fc, input int hc);
        int fp, rp, hp, dt, dl;
        fp = (md ? F_L : F_N) << ((fc > 10) ? 10 : fc);
        rp = (md ? R_L : R_N) << ((rc > 10) ? 10 : rc);
        hp = (hc == 0) ? 0 : H_B << (((hc > 9) ? 9 : hc) - 1);
        mag = 16'h7fff;
        i_manual_input_gain = 6'h3f;
        wr(7'h22, {md, 4'(rc), 4'(fc)});
        wr(7'h21, {1'b0, 4'(hc), 4'h5});
        wr(7'h20, 9'h111);
        repeat (2) @(posedge i_ref_clk);
        #1 chk("entry_gain", 16'd23, 16'(o_input_gain));
        for (int k = 0; k < 15; k++) begin
            step(4 * fp + 64, dt, dl);
            chk("fall_step", 16'hffff, 16'(dl));
            if (k > 0) chk("fall_time", 16'(fp), 16'(dt));
        end
        step(4 * fp + 64, dt, dl);
        chk("floor", 16'd8, 16'(o_input_gain));
        mag = 16'(int'(level_ctrl_pkg::TARGET_TABLE[5]) - 1
                  - int'($urandom % 500));
        step(hp + 4 * rp + 64, dt, dl);
        chk("hold_time", 16'h1, 16'(dt >= hp && dt <= hp + rp + 16));
        for (int k = 0; k < 14; k++) begin
            step(4 * rp + 64, dt, dl);
            chk("rise_step", 16'h1, 16'(dl));
            chk("rise_time", 16'(rp), 16'(dt));
        end
        step(4 * rp + 64, dt, dl);
        chk("ceiling", 16'd23, 16'(o_input_gain));
    endtask

    initial begin
        void'($urandom(32'hfeaa));
        repeat (8) @(posedge i_ref_clk);
        #1 i_sys_rst = 1'b0;
        rd(7'h20, 9'h038);
        rd(7'h21, 9'h00b);
        rd(7'h22, 9'h032);
        rd(7'h23, 9'h000);
        for (int i = 0; i < 3; i++) begin
            d = 9'($urandom) & ((i == 0) ? 9'h0ff : 9'h1ff);
            wr(7'h20 + 7'(i), d);
            rd(7'h20 + 7'(i), (i == 0) ? (d & 9'h13f) : d);
            if (i == 1) chk("zero_cross", 16'(d[8]), 16'(o_zero_cross_update));
        end
        repeat (4) begin
            i_manual_input_gain = 6'($urandom);
            repeat (2) @(posedge i_ref_clk);
            #1 chk("manual", 16'(i_manual_input_gain), 16'(o_input_gain));
        end
        for (int c = 0; c < 16; c++) begin
            wr(7'h21, 9'(c));
            mag = level_ctrl_pkg::TARGET_TABLE[c] + 16'($urandom % 50) + 16'h1;
            repeat (6) @(posedge i_ref_clk);
            #1 chk("above", 16'h1, 16'(o_level_above));
            mag = level_ctrl_pkg::TARGET_TABLE[c];
            repeat (6) @(posedge i_ref_clk);
            #1 chk("not_above", 16'h0, 16'(o_level_above));
        end
        run(1'b0, 0, 0, 1);
        run(1'b0, 2, 3, 0);
        run(1'b1, 10, 12, 9);
        wr(7'h20, 9'h000);
        i_manual_input_gain = 6'($urandom);
        repeat (2) @(posedge i_ref_clk);
        #1 chk("manual_back", 16'(i_manual_input_gain), 16'(o_input_gain));
        results();
    end
endmodule
